// file: include/rx_filter_cfg.svh
// offsets, field positions, reset values and sizes of the receive filter
`ifndef RX_FILTER_CFG_SVH
`define RX_FILTER_CFG_SVH
// register indexes; byte address is four times the index
`define IDX_RX_CONTROL_SECOND   8'h76
`define IDX_TX_QUEUE_FREE_MEM   8'h78
`define IDX_RX_FRAME_STATUS     8'h7c
`define IDX_STATION_ADDR_LOW    8'h70
`define IDX_STATION_ADDR_MID    8'h71
`define IDX_STATION_ADDR_HIGH   8'h72
`define IDX_IRQ_STATUS          8'h60
`define IDX_IRQ_CLEAR           8'h61
`define IDX_IRQ_ENABLE          8'h62
`define IDX_FRAME_RELEASE       8'h63
`define IDX_RX_FRAME_COUNTER    8'h64
// rx_control_second fields
`define CTL_BURST_HI            7
`define CTL_BURST_LO            5
`define CTL_FRAG_PASS           4
`define CTL_ZERO_PASS           3
`define CTL_LITE_EN             2
`define CTL_ICMP_EN             1
`define CTL_SRC_DROP            0
`define CTL_LITE_RESET          1'h1
`define CTL_BURST_RESET         3'h0
// burst length codes
`define BURST_4                 3'h0
`define BURST_8                 3'h1
`define BURST_16                3'h2
`define BURST_32                3'h3
`define BURST_FRAME             3'h4
// rx_frame_status fields
`define ST_VALID                15
`define ST_ICMP_BAD             13
`define ST_IP_BAD               12
`define ST_TCP_BAD              11
`define ST_UDP_BAD              10
`define ST_BCAST                7
`define ST_MCAST                6
`define ST_UCAST                5
`define ST_SYMBOL               4
// interrupt bits
`define IRQ_ACCEPT              0
`define IRQ_DROP                1
`define IRQ_OVERFLOW            2
`define IRQ_WIDTH               3
// status queue
`define STQ_DEPTH               4
`define STQ_PTR_W               2
`define STQ_CNT_W               3
`endif

// file: include/rx_filter_pkg.sv
// types shared by the receive filter, its bench and the bus host model
package rx_filter_pkg;
  // per-frame facts from the receive parser, valid with frameDone
  typedef struct packed {
    logic        isUdp;
    logic        isUdpLite;
    logic        isIcmp;
    logic        isFragment;
    logic        udpSumZero;
    logic        icmpBad;
    logic        ipBad;
    logic        tcpBad;
    logic        udpBad;
    logic        bcast;
    logic        mcast;
    logic        ucast;
    logic        symbolErr;
    logic [47:0] srcAddr;
  } rx_frame_info_t;
  // classic wishbone request
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [9:0]  adr;
    logic [31:0] dat;
  } wb_req_t;
endpackage : rx_filter_pkg

// file: rtl/rx_checksum_filter_status.sv
// receive checksum filter, frame status and transmit free-memory report
`timescale 1ns/100ps
`include "rx_filter_cfg.svh"
// Operation
// - three-bit write-only field selects host burst length
// - fragment pass lets UDP fragments skip checksum
// - zero UDP checksum passes or drops per control
// - UDP-Lite checksum check and insert when enabled
// - drop non-fragment ICMP frames with bad checksum
// - drop frames sourced from own station address
// - report free transmit-queue bytes, 13 bits
// - frame valid only when completed frame pending
// - separate bad-checksum bits for ICMP, IP, TCP, UDP
// - broadcast, multicast and unicast class bits
// - flag MII symbol error of reported frame
// - status presented once per counted frame
module rx_checksum_filter_status (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire rx_filter_pkg::wb_req_t      wbReq,
  output logic      [31:0]                 wbDatOut,
  output logic                             wbAck,
  input  wire logic                        frameDone,
  input  wire rx_filter_pkg::rx_frame_info_t frameInfo,
  input  wire logic [12:0]                 txFreeBytes,
  output logic                             frameAccept,
  output logic                             frameDrop,
  output logic      [2:0]                  burstLenSel,
  output logic      [5:0]                  burstBytes,
  output logic                             burstWholeFrame,
  output logic                             udpLiteTxSumEn,
  output logic      [`STQ_CNT_W-1:0]       rxFrameCount,
  output logic                             irq
);
  // burst length in bytes for a code, zero for whole frame or reserved
  function automatic logic [5:0] burstDecode(input logic [2:0] code);
    case (code)
      `BURST_4:  burstDecode = 6'h04;
      `BURST_8:  burstDecode = 6'h08;
      `BURST_16: burstDecode = 6'h10;
      `BURST_32: burstDecode = 6'h20;
      default:   burstDecode = 6'h00;
    endcase
  endfunction : burstDecode

  // control fields
  logic [2:0]  burst_reg, burst_next;      // host burst code
  logic        frag_reg, frag_next;        // udp_fragment_pass
  logic        zero_reg, zero_next;        // udp_zero_sum_pass
  logic        lite_reg, lite_next;        // udp_lite_sum_en
  logic        icmp_reg, icmp_next;        // icmp_sum_check_en
  logic        srcd_reg, srcd_next;        // own_source_drop_en
  logic [15:0] sta_reg [3];                // station_addr low/mid/high
  logic [15:0] sta_next [3];
  logic [`IRQ_WIDTH-1:0] ist_reg, ist_next; // sticky events
  logic [`IRQ_WIDTH-1:0] ien_reg, ien_next; // event enables
  // bus state
  logic        ack_reg, ack_next;
  logic [31:0] dat_reg, dat_next;
  logic        acc_reg, acc_next;          // accept pulse
  logic        drp_reg, drp_next;          // drop pulse
  // decoding helpers
  logic        req, wrStb;
  logic [7:0]  idx;
  logic [15:0] wd;
  logic [15:0] head, statusWord, pushWord;
  logic        udpBadEff, dropIt, popHead;
  logic [`IRQ_WIDTH-1:0] events;

  assign req   = wbReq.cyc && wbReq.stb;
  assign idx   = wbReq.adr[9:2];
  assign wd    = wbReq.dat[15:0];
  // a write lands on the edge at which the master sees ack
  assign wrStb = req && wbReq.we && ack_reg;

  // filtering decision on the completing frame
  always_comb begin
    // fragments with fragment pass set and disabled UDP-Lite skip the UDP sum check
    udpBadEff = frameInfo.udpBad
      && !(frameInfo.isFragment && frag_reg)
      && !(frameInfo.isUdpLite && !lite_reg);
    dropIt = 1'b0;
    if (frameInfo.isUdp && frameInfo.udpSumZero && !zero_reg) begin
      dropIt = 1'b1;
    end
    if (icmp_reg && frameInfo.isIcmp && !frameInfo.isFragment
        && frameInfo.icmpBad) begin
      dropIt = 1'b1;
    end
    if (srcd_reg && frameInfo.srcAddr ==
        {sta_reg[2], sta_reg[1], sta_reg[0]}) begin
      dropIt = 1'b1;
    end
    // multicast also covers broadcast
    pushWord = 16'h0000;
    pushWord[`ST_ICMP_BAD] = frameInfo.icmpBad;
    pushWord[`ST_IP_BAD]   = frameInfo.ipBad;
    pushWord[`ST_TCP_BAD]  = frameInfo.tcpBad;
    pushWord[`ST_UDP_BAD]  = udpBadEff;
    pushWord[`ST_BCAST]    = frameInfo.bcast;
    pushWord[`ST_MCAST]    = frameInfo.mcast || frameInfo.bcast;
    pushWord[`ST_UCAST]    = frameInfo.ucast;
    pushWord[`ST_SYMBOL]   = frameInfo.symbolErr;
  end

  // host release of the head frame moves status on
  assign popHead = wrStb && idx == `IDX_FRAME_RELEASE
                   && wbReq.sel[0] && wd[0];

  // one entry per accepted frame, so reads repeat the same status
  rx_status_queue u_queue (
    .clk      (clk),
    .rst_n    (rst_n),
    .pushValid(frameDone && !dropIt),
    .pushData (pushWord),
    .popReq   (popHead),
    .headData (head),
    .count    (rxFrameCount)
  );

  // valid only while a completed frame sits at the head
  always_comb begin
    statusWord = head;
    statusWord[`ST_VALID] = (rxFrameCount != '0);
  end

  // events for the interrupt block
  always_comb begin
    events = '0;
    events[`IRQ_ACCEPT]   = frameDone && !dropIt &&
      (rxFrameCount != `STQ_CNT_W'(`STQ_DEPTH));
    events[`IRQ_DROP]     = frameDone && dropIt;
    events[`IRQ_OVERFLOW] = frameDone && !dropIt &&
      (rxFrameCount == `STQ_CNT_W'(`STQ_DEPTH));
  end

  // register writes, interrupt bookkeeping and bus answer
  always_comb begin
    burst_next = burst_reg;
    frag_next  = frag_reg;
    zero_next  = zero_reg;
    lite_next  = lite_reg;
    icmp_next  = icmp_reg;
    srcd_next  = srcd_reg;
    sta_next   = sta_reg;
    ien_next   = ien_reg;
    ist_next   = ist_reg;
    acc_next   = events[`IRQ_ACCEPT];
    drp_next   = events[`IRQ_DROP];
    // answer one cycle after the request, drop ack the cycle after
    ack_next   = req && !ack_reg;
    dat_next   = dat_reg;
    if (wrStb && wbReq.sel[0]) begin
      case (idx)
        `IDX_RX_CONTROL_SECOND: begin
          burst_next = wd[`CTL_BURST_HI:`CTL_BURST_LO];
          frag_next  = wd[`CTL_FRAG_PASS];
          zero_next  = wd[`CTL_ZERO_PASS];
          lite_next  = wd[`CTL_LITE_EN];
          icmp_next  = wd[`CTL_ICMP_EN];
          srcd_next  = wd[`CTL_SRC_DROP];
        end
        `IDX_STATION_ADDR_LOW:  sta_next[0][7:0] = wd[7:0];
        `IDX_STATION_ADDR_MID:  sta_next[1][7:0] = wd[7:0];
        `IDX_STATION_ADDR_HIGH: sta_next[2][7:0] = wd[7:0];
        `IDX_IRQ_ENABLE:        ien_next = wd[`IRQ_WIDTH-1:0];
        `IDX_IRQ_CLEAR:
          ist_next = ist_reg & ~wd[`IRQ_WIDTH-1:0];
        default: ;
      endcase
    end
    if (wrStb && wbReq.sel[1]) begin
      case (idx)
        `IDX_STATION_ADDR_LOW:  sta_next[0][15:8] = wd[15:8];
        `IDX_STATION_ADDR_MID:  sta_next[1][15:8] = wd[15:8];
        `IDX_STATION_ADDR_HIGH: sta_next[2][15:8] = wd[15:8];
        default: ;
      endcase
    end
    // a new event wins over a clear in the same cycle
    ist_next = ist_next | events;
    // read data captured as ack rises; unmapped reads give zero
    if (req && !ack_reg) begin
      dat_next = 32'h0000_0000;
      case (idx)
        // burst code is write-only and reads back as zero
        `IDX_RX_CONTROL_SECOND:
          dat_next[4:0] = {frag_reg, zero_reg, lite_reg, icmp_reg, srcd_reg};
        `IDX_TX_QUEUE_FREE_MEM: dat_next[12:0] = txFreeBytes;
        `IDX_RX_FRAME_STATUS:   dat_next[15:0] = statusWord;
        `IDX_STATION_ADDR_LOW:  dat_next[15:0] = sta_reg[0];
        `IDX_STATION_ADDR_MID:  dat_next[15:0] = sta_reg[1];
        `IDX_STATION_ADDR_HIGH: dat_next[15:0] = sta_reg[2];
        `IDX_IRQ_STATUS:   dat_next[`IRQ_WIDTH-1:0] = ist_reg;
        `IDX_IRQ_ENABLE:   dat_next[`IRQ_WIDTH-1:0] = ien_reg;
        `IDX_RX_FRAME_COUNTER: dat_next[`STQ_CNT_W-1:0] = rxFrameCount;
        default: ;
      endcase
    end
  end

  // registers only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      burst_reg <= `CTL_BURST_RESET;
      frag_reg  <= 1'b0;
      zero_reg  <= 1'b0;
      lite_reg  <= `CTL_LITE_RESET;
      icmp_reg  <= 1'b0;
      srcd_reg  <= 1'b0;
      for (int i = 0; i < 3; i++) begin
        sta_reg[i] <= 16'h0000;
      end
      ist_reg   <= '0;
      ien_reg   <= '0;
      ack_reg   <= 1'b0;
      dat_reg   <= 32'h0000_0000;
      acc_reg   <= 1'b0;
      drp_reg   <= 1'b0;
    end else begin
      burst_reg <= burst_next;
      frag_reg  <= frag_next;
      zero_reg  <= zero_next;
      lite_reg  <= lite_next;
      icmp_reg  <= icmp_next;
      srcd_reg  <= srcd_next;
      sta_reg   <= sta_next;
      ist_reg   <= ist_next;
      ien_reg   <= ien_next;
      ack_reg   <= ack_next;
      dat_reg   <= dat_next;
      acc_reg   <= acc_next;
      drp_reg   <= drp_next;
    end
  end

  // outputs
  assign wbAck           = ack_reg;
  assign wbDatOut        = dat_reg;
  assign frameAccept     = acc_reg;
  assign frameDrop       = drp_reg;
  assign burstLenSel     = burst_reg;
  assign burstBytes      = burstDecode(burst_reg);
  assign burstWholeFrame = (burst_reg == `BURST_FRAME);
  assign udpLiteTxSumEn  = lite_reg;
  assign irq             = |(ist_reg & ien_reg);

  // checks
  sequence sCtlWrite(logic [2:0] code);
    wrStb && wbReq.sel[0] && idx == `IDX_RX_CONTROL_SECOND
      && wd[7:5] == code;
  endsequence
  sequence sUdpZero;
    frameDone && frameInfo.isUdp && frameInfo.udpSumZero;
  endsequence

  a_burst_thirtytwo: assert property (
    @(posedge clk) disable iff (!rst_n)
    sCtlWrite(3'h3) |=> burstBytes == 6'h20 && !burstWholeFrame)
    else $error("burst code 3 not decoded as 32 bytes");
  a_burst_frame: assert property (
    @(posedge clk) disable iff (!rst_n)
    sCtlWrite(3'h4) |=> burstWholeFrame && burstBytes == 6'h00)
    else $error("burst code 4 not decoded as whole frame");
  a_zero_drop: assert property (
    @(posedge clk) disable iff (!rst_n)
    sUdpZero ##0 !zero_reg |=> frameDrop && !frameAccept)
    else $error("zero-sum udp frame not dropped");
  a_zero_pass: assert property (
    @(posedge clk) disable iff (!rst_n)
    sUdpZero ##0 (zero_reg && !srcd_reg && !frameInfo.isIcmp)
      |=> !frameDrop)
    else $error("zero-sum udp frame dropped while passing");
  a_icmp_drop: assert property (
    @(posedge clk) disable iff (!rst_n)
    frameDone && icmp_reg && frameInfo.isIcmp && !frameInfo.isFragment
      && frameInfo.icmpBad |=> frameDrop)
    else $error("bad icmp frame not dropped");
  a_own_source: assert property (
    @(posedge clk) disable iff (!rst_n)
    frameDone && srcd_reg &&
      frameInfo.srcAddr == {sta_reg[2], sta_reg[1], sta_reg[0]}
      |=> frameDrop ##1 (!frameDrop || $past(frameDone)))
    else $error("own source frame not dropped");
  a_valid_clear: assert property (
    @(posedge clk) disable iff (!rst_n)
    rxFrameCount == `STQ_CNT_W'(1) && popHead && !frameDone
      |=> !statusWord[`ST_VALID])
    else $error("frame valid stays after last release");
  a_valid_set: assert property (
    @(posedge clk) disable iff (!rst_n)
    rxFrameCount == '0 && frameDone && !dropIt
      |=> statusWord[`ST_VALID] && statusWord[`ST_SYMBOL]
          == $past(frameInfo.symbolErr))
    else $error("accepted frame status not presented");
  a_lite_ignore: assert property (
    @(posedge clk) disable iff (!rst_n)
    rxFrameCount == '0 && frameDone && !dropIt && !lite_reg
      && frameInfo.isUdpLite |=> !statusWord[`ST_UDP_BAD])
    else $error("udp-lite sum checked while disabled");
  a_ack_once: assert property (
    @(posedge clk) disable iff (!rst_n)
    req && !ack_reg |=> wbAck ##1 !wbAck)
    else $error("ack not a single cycle");
endmodule : rx_checksum_filter_status

// file: rtl/rx_status_queue.sv
// flip-flop queue of per-frame status words
`timescale 1ns/100ps
`include "rx_filter_cfg.svh"
module rx_status_queue (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   pushValid,
  input  wire logic [15:0]            pushData,
  input  wire logic                   popReq,
  output logic      [15:0]            headData,
  output logic      [`STQ_CNT_W-1:0]  count
);
  logic [15:0]           mem_reg  [`STQ_DEPTH];  // status words
  logic [15:0]           mem_next [`STQ_DEPTH];
  logic [`STQ_PTR_W-1:0] rd_reg, rd_next;        // head index
  logic [`STQ_PTR_W-1:0] wr_reg, wr_next;        // tail index
  logic [`STQ_CNT_W-1:0] cnt_reg, cnt_next;      // entries held
  logic                  doPush, doPop;

  // push refused when full; the caller sees that through count
  always_comb begin
    doPush   = pushValid && (cnt_reg != `STQ_CNT_W'(`STQ_DEPTH));
    doPop    = popReq && (cnt_reg != '0);
    mem_next = mem_reg;
    rd_next  = rd_reg;
    wr_next  = wr_reg;
    cnt_next = cnt_reg;
    if (doPush) begin
      mem_next[wr_reg] = pushData;
      wr_next          = wr_reg + 1'b1;
    end
    if (doPop) begin
      rd_next = rd_reg + 1'b1;
    end
    if (doPush && !doPop) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (doPop && !doPush) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  // storage and pointers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `STQ_DEPTH; i++) begin
        mem_reg[i] <= 16'h0000;
      end
      rd_reg  <= '0;
      wr_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      mem_reg <= mem_next;
      rd_reg  <= rd_next;
      wr_reg  <= wr_next;
      cnt_reg <= cnt_next;
    end
  end

  assign headData = mem_reg[rd_reg];
  assign count    = cnt_reg;
endmodule : rx_status_queue

// file: test/tb_rx_checksum_filter_status.sv
// self-checking bench for the receive filter and frame status block
`timescale 1ns/100ps
module tb_rx_checksum_filter_status;
  logic                          clk = 1'b0;      // 20 MHz clock
  logic                          rst_n = 1'b0;    // async reset
  rx_filter_pkg::wb_req_t        wbReq;           // from host model
  rx_filter_pkg::rx_frame_info_t frameInfo = '0;  // parser facts
  logic [31:0] wbDatOut;
  logic        wbAck, frameAccept, frameDrop, burstWholeFrame, irq;
  logic        frameDone = 1'b0, udpLiteTxSumEn;
  logic [12:0] txFreeBytes = 13'h0000;
  logic [2:0]  burstLenSel, rxFrameCount;
  logic [5:0]  burstBytes;
  int          errorCnt = 0, nCompared = 0;
  logic [15:0] q[$];              // model of the pending status words
  int          expQ[$];           // 0 accept, 1 drop, 2 lost to full
  logic [4:0]  ctrl = 5'h04;      // model copy of control bits 4:0
  logic [2:0]  irqExp = 3'h0;     // model of sticky event bits
  logic [47:0] station;
  logic [15:0] rdat;

  always #25 clk = ~clk;

  wb_host_model u_host (.clk(clk), .wbReq(wbReq), .wbDatOut(wbDatOut),
                        .wbAck(wbAck));
  rx_checksum_filter_status u_dut (.clk(clk), .rst_n(rst_n),
    .wbReq(wbReq), .wbDatOut(wbDatOut), .wbAck(wbAck),
    .frameDone(frameDone), .frameInfo(frameInfo),
    .txFreeBytes(txFreeBytes), .frameAccept(frameAccept),
    .frameDrop(frameDrop), .burstLenSel(burstLenSel),
    .burstBytes(burstBytes), .burstWholeFrame(burstWholeFrame),
    .udpLiteTxSumEn(udpLiteTxSumEn), .rxFrameCount(rxFrameCount),
    .irq(irq));

  // compare and count; four-state compare so an unknown matches only an unknown
  task automatic chk(input string what, input logic [15:0] exp, got);
    nCompared++;
    if (got !== exp) begin
      errorCnt++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] idx, input logic [15:0] d);
    u_host.xfer(1'b1, idx, d, rdat);
  endtask : wr

  task automatic rd(input string what, input logic [7:0] idx,
                    input logic [15:0] exp);
    u_host.xfer(1'b0, idx, 16'h0000, rdat);
    chk(what, exp, rdat);
  endtask : rd

  // back-to-back random frames; pulses checked two edges after drive
  task automatic frames(input int n);
    rx_filter_pkg::rx_frame_info_t fi;
    logic [63:0] rv;
    logic        pass, udpOk;
    int          code;
    for (int i = 0; i <= n + 1; i++) begin
      @(posedge clk);
      frameDone <= (i < n);
      if (i < n) begin
        rv = {$urandom, $urandom};
        fi = rv[60:0];
        // keep the parser facts consistent with each other
        fi.isUdp = fi.isUdp | fi.isUdpLite | fi.isFragment;
        fi.mcast = fi.mcast | fi.bcast;
        if (rv[63]) fi.srcAddr = station;
        pass = !(ctrl[0] && fi.srcAddr == station)
          && !(fi.isUdp && fi.udpSumZero && !ctrl[3])
          && !(ctrl[1] && fi.isIcmp && !fi.isFragment && fi.icmpBad);
        udpOk = (ctrl[4] && fi.isFragment) || (!ctrl[2] && fi.isUdpLite);
        code = !pass ? 1 : (q.size() < 4 ? 0 : 2);
        if (code == 0) q.push_back({2'b10, fi.icmpBad, fi.ipBad,
          fi.tcpBad, fi.udpBad && !udpOk, 2'b00, fi.bcast, fi.mcast,
          fi.ucast, fi.symbolErr, 4'h0});
        irqExp[code] = 1'b1;
        expQ.push_back(code);
        frameInfo <= fi;
      end
      if (i >= 2) begin
        code = expQ.pop_front();
        chk("frameAccept", 16'(code == 0), 16'(frameAccept));
        // a lost frame has no documented drop pulse, so skip it
        if (code < 2) chk("frameDrop", 16'(code == 1), 16'(frameDrop));
      end
    end
  endtask : frames

  // read each head twice, then release it, until empty
  task automatic drain();
    chk("rxFrameCount", 16'(q.size()), 16'(rxFrameCount));
    rd("frameCounter", 8'h64, 16'(q.size()));
    while (q.size() > 0) begin
      rd("status", 8'h7c, q[0]);
      rd("status again", 8'h7c, q[0]);
      wr(8'h63, 16'h0001);
      void'(q.pop_front());
    end
    u_host.xfer(1'b0, 8'h7c, 16'h0000, rdat);
    chk("status valid", 16'h0000, 16'(rdat[15]));
    chk("rxFrameCount", 16'h0000, 16'(rxFrameCount));
  endtask : drain

  task automatic results();
    $display("compared %0d, mismatches %0d", nCompared, errorCnt);
    if (errorCnt == 0 && nCompared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results

  // watchdog at 40000 cycles; the whole sequence needs well under that
  initial begin
    #2000000;
    errorCnt++;
    results();
  end

  initial begin
    void'($urandom(32'h351d4605));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd("control", 8'h76, 16'h0004);
    chk("burstBytes", 16'h0004, 16'(burstBytes));
    chk("udpLiteTxSumEn", 16'h0001, 16'(udpLiteTxSumEn));
    $display("test reset done");
    // every burst code, reserved ones too; field reads back 0
    for (int c = 0; c < 8; c++) begin
      wr(8'h76, 16'(c << 5) | 16'h0004);
      @(negedge clk);
      chk("burstLenSel", 16'(c), 16'(burstLenSel));
      chk("burstBytes", c < 4 ? 16'(4 << c) : 16'h0000, 16'(burstBytes));
      chk("burstWholeFrame", 16'(c == 4), 16'(burstWholeFrame));
      rd("control", 8'h76, 16'h0004);
    end
    $display("test burst done");
    repeat (4) begin
      @(posedge clk);
      txFreeBytes <= 13'($urandom);
      @(negedge clk);
      rd("txFree", 8'h78, {3'b000, txFreeBytes});
    end
    $display("test tx free done");
    station = 48'({$urandom, $urandom});
    wr(8'h70, station[15:0]);
    wr(8'h71, station[31:16]);
    wr(8'h72, station[47:32]);
    rd("stationLow", 8'h70, station[15:0]);
    rd("stationHigh", 8'h72, station[47:32]);
    // random control settings against random frames
    repeat (12) begin
      ctrl = 5'($urandom);
      wr(8'h76, {11'h000, ctrl});
      @(negedge clk);
      chk("udpLiteTxSumEn", 16'(ctrl[2]), 16'(udpLiteTxSumEn));
      frames(1 + $urandom % 3);
      drain();
    end
    $display("test filter done");
    // interrupt: masked, enabled, overflow, cleared
    rd("irqStatus", 8'h60, {13'h0000, irqExp});
    chk("irq masked", 16'h0000, 16'(irq));
    ctrl = 5'h0c;
    wr(8'h76, 16'h000c);
    frames(5);
    chk("rxFrameCount full", 16'h0004, 16'(rxFrameCount));
    rd("irqStatus", 8'h60, {13'h0000, irqExp});
    wr(8'h62, 16'h0007);
    @(negedge clk);
    chk("irq enabled", 16'h0001, 16'(irq));
    wr(8'h62, 16'h0000);
    @(negedge clk);
    chk("irq masked", 16'h0000, 16'(irq));
    wr(8'h62, 16'h0007);
    wr(8'h61, 16'h0007);
    irqExp = 3'h0;
    @(negedge clk);
    chk("irq cleared", 16'h0000, 16'(irq));
    rd("irqStatus", 8'h60, 16'h0000);
    drain();
    $display("test irq done");
    results();
  end
endmodule : tb_rx_checksum_filter_status

// file: test/wb_host_model.sv
// host-side register bus master model, classic single cycles
`timescale 1ns/100ps
module wb_host_model (
  input  wire logic                   clk,
  output rx_filter_pkg::wb_req_t      wbReq,
  input  wire logic [31:0]            wbDatOut,
  input  wire logic                   wbAck
);
  // bus idle from time zero so nothing is taken during reset
  initial wbReq = '0;

  // one cycle: request held until ack is sampled high, then released
  task automatic xfer(input logic we, input logic [7:0] idx,
                      input logic [15:0] d, output logic [15:0] r);
    @(posedge clk);
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'h3,
               adr: {idx, 2'b00}, dat: {16'h0000, d}};
    // no latency assumed; the bench watchdog ends a dead wait
    do begin
      @(posedge clk);
    end while (wbAck !== 1'b1);
    r = wbDatOut[15:0];
    wbReq <= '0;
  endtask : xfer
endmodule : wb_host_model
